// File: opsq_pkg.sv
// Package: types and constants of the on/off power sequencer
// ****************************************************************
// Overview of operation
// - Resource On is entered only after power-up completes, bias and serial on.
// - Cold-reset 0b01, power-off 0b10 or manual reset starts power-down.
// - Soft standby command leaves Resource On heading for Standby.
// - Standby keeps every sequenced output channel off.
// - Channels forced on by code 0x6 or 0x7 stay on in Standby.
// - Standby keeps main bias and serial interface running.
// - Standby bias runs low-power when the low-power select bit is 1.
// - Finished power-down moves to Standby or to the bias-off step.
// - Standby wakes on button press, exit-standby command or manual reset.
// - Lockout faults force immediate shutdown, then go toward Shutdown.
// - Logic mode with the on-key high powers the device down.
// - Reaching Shutdown after a cold reset keeps a wake flag that restarts.
// - Wake flag sets on a debounced press in button mode or any debounced change in slide mode.
// - Wake flag sets on a low on-key in logic mode.
// - Wake flag sets on the cold-reset code 0b01.
// - Channels power up by sequencer or software, alone or grouped.
// - One master timer makes four events; channels pick up and down slots.
// - Power-down lasts at most four 2.56ms slots plus 125ms.
// - In Standby, low-power select 1 puts bias and regulator control in sampled mode.
// - Wake proceeds to power-up only with all reset-cause faults clear.
// - Resource On is entered when power-up completes.
// - In logic mode a low on-key wakes the device from Shutdown.
// - Code 0x3 requests Standby by power-down; 0x4 exits Standby.
// ****************************************************************
`default_nettype none
package opsq_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int SLOT_US = 2560;
  localparam int DISCH_US = 125_000;
  localparam int DEB_US = 30_000;
  localparam int SLOT_CYC = (SLOT_US * (CLK_HZ / 1_000_000));
  localparam int DISCH_CYC = (DISCH_US * (CLK_HZ / 1_000_000));
  localparam int DEB_CYC = (DEB_US * (CLK_HZ / 1_000_000));
  localparam int CNT_W = 21;
  localparam int NCH = 4;
  localparam logic [2:0] LAST_SLOT = 3'h3;
  localparam logic [2:0] DISCH_SLOT = 3'h4;
  localparam logic [1:0] MODE_PB = 2'h0;
  localparam logic [1:0] MODE_SLIDE = 2'h1;
  localparam logic [1:0] MODE_LOGIC = 2'h2;
  localparam logic [2:0] SC_COLD = 3'h1;
  localparam logic [2:0] SC_OFF = 3'h2;
  localparam logic [2:0] SC_STBY = 3'h3;
  localparam logic [2:0] SC_EXIT = 3'h4;
  localparam logic [2:0] EN_FORCE_A = 3'h6;
  localparam logic [2:0] EN_FORCE_B = 3'h7;
  localparam logic KEY_RST = 1'h1;
  typedef enum logic [7:0] {
    ST_SHDN = 8'h01,
    ST_WAKE = 8'h02,
    ST_PUP = 8'h04,
    ST_RON = 8'h08,
    ST_PDN = 8'h10,
    ST_STBY = 8'h20,
    ST_IMSD = 8'h40,
    ST_BOFF = 8'h80
  } opsq_state_e;
  typedef struct packed {
    logic undervoltage_lockout_flag;
    logic overvoltage_lockout_flag;
    logic thermal_overload_flag;
  } opsq_cause_s;
  typedef struct packed {
    logic wr;
    logic [2:0] code;
  } opsq_cmd_s;
endpackage : opsq_pkg
`default_nettype wire

// File: opsq_seq_timer.sv
// Master sequencing timer: four slot events plus discharge wait
`default_nettype none
module opsq_seq_timer #(
  parameter int SLOT_CYC = opsq_pkg::SLOT_CYC,
  parameter int DISCH_CYC = opsq_pkg::DISCH_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_start_up,
  input wire logic i_start_dn,
  input wire logic i_abort,
  output logic o_evt,
  output logic [1:0] o_slot,
  output logic o_done,
  output logic o_busy
);
  typedef struct packed {
    logic busy;
    logic dn;
    logic [2:0] slot;
    logic [opsq_pkg::CNT_W-1:0] cnt;
    logic evt;
    logic [1:0] idx;
    logic done;
  } opsq_tmr_s;
  opsq_tmr_s q;
  opsq_tmr_s d;
  logic [opsq_pkg::CNT_W-1:0] lim;

  assign lim = (q.slot == opsq_pkg::DISCH_SLOT) ? opsq_pkg::CNT_W'(DISCH_CYC - 1)
                                                 : opsq_pkg::CNT_W'(SLOT_CYC - 1);

  always_comb
  begin
    d = q;
    d.evt = 1'b0;
    d.done = 1'b0;
    if (i_abort)
    begin
      d.busy = 1'b0;
    end
    else if (i_start_up || i_start_dn)
    begin
      d.busy = 1'b1;
      d.dn = i_start_dn;
      d.slot = '0;
      d.cnt = '0;
    end
    else if (q.busy)
    begin
      if (q.cnt != lim)
      begin
        d.cnt = q.cnt + opsq_pkg::CNT_W'(1);
      end
      else
      begin
        d.cnt = '0;
        d.slot = q.slot + 3'h1;
        if (q.slot != opsq_pkg::DISCH_SLOT)
        begin
          d.evt = 1'b1;
          d.idx = q.slot[1:0];
        end
        // Power-down adds the discharge wait after the last slot
        if (q.slot == opsq_pkg::DISCH_SLOT || (q.slot == opsq_pkg::LAST_SLOT && !q.dn))
        begin
          d.done = 1'b1;
          d.busy = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      q <= '0;
    else if (i_ce)
      q <= d;
  end

  assign o_evt = q.evt;
  assign o_slot = q.idx;
  assign o_done = q.done;
  assign o_busy = q.busy;
endmodule : opsq_seq_timer
`default_nettype wire

// File: opsq_on_off_ctrl.sv
// On/off controller with channel sequencing, wake flag and debounce
`default_nettype none
module opsq_on_off_ctrl #(
  parameter int SLOT_CYC = opsq_pkg::SLOT_CYC,
  parameter int DISCH_CYC = opsq_pkg::DISCH_CYC,
  parameter int DEB_CYC = opsq_pkg::DEB_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_on_key_input_n,
  input wire logic [1:0] i_on_key_mode_select,
  input wire opsq_pkg::opsq_cmd_s i_soft_control_field,
  input wire logic i_manual_reset,
  input wire opsq_pkg::opsq_cause_s i_fault,
  input wire logic i_cause_clr,
  input wire logic i_bias_low_power_select,
  input wire logic [3:0][2:0] i_channel_enable_field,
  input wire logic [3:0][1:0] i_up_slot,
  input wire logic [3:0][1:0] i_dn_slot,
  output opsq_pkg::opsq_state_e o_state,
  output logic [3:0] o_channel_on,
  output logic o_bias_on,
  output logic o_bias_lp,
  output logic o_ctrl_lp,
  output logic o_serial_on,
  output opsq_pkg::opsq_cause_s o_reset_cause_flags,
  output logic o_wake_flag
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    opsq_pkg::opsq_state_e st;
    logic tgt_stby;
    logic wake;
    logic [3:0] on;
    logic [2:0] cause;
    logic [1:0] key_sy;
    logic key_deb;
    logic [opsq_pkg::CNT_W-1:0] deb_cnt;
    logic [2:0] flt_m;
    logic [2:0] flt_s;
  } opsq_main_s;

  opsq_main_s q;
  opsq_main_s d;
  logic key_s;
  logic fault;
  logic deb_evt;
  logic pb_fall;
  logic cmd_ok;
  logic [2:0] code;
  logic [3:0] forced;
  logic tmr_up;
  logic tmr_dn;
  logic tmr_abort;
  logic tmr_evt;
  logic [1:0] tmr_slot;
  logic tmr_done;

  function automatic logic is_forced(input logic [2:0] c);
    return (c == opsq_pkg::EN_FORCE_A) || (c == opsq_pkg::EN_FORCE_B);
  endfunction : is_forced

  // Serial control only answers in power-up, Resource On, power-down and Standby
  function automatic logic serial_live(input opsq_pkg::opsq_state_e s);
    return (s == opsq_pkg::ST_PUP) || (s == opsq_pkg::ST_RON) ||
           (s == opsq_pkg::ST_PDN) || (s == opsq_pkg::ST_STBY);
  endfunction : serial_live

  function automatic logic is_dead(input opsq_pkg::opsq_state_e s);
    return (s == opsq_pkg::ST_SHDN) || (s == opsq_pkg::ST_IMSD) ||
           (s == opsq_pkg::ST_BOFF) || (s == opsq_pkg::ST_WAKE);
  endfunction : is_dead

  for (genvar g = 0; g < opsq_pkg::NCH; g++)
  begin : g_force
    assign forced[g] = is_forced(i_channel_enable_field[g]);
  end

  assign key_s = q.key_sy[1];
  assign fault = |q.flt_s;
  assign code = i_soft_control_field.code;
  assign cmd_ok = i_soft_control_field.wr && serial_live(q.st);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    d = q;
    deb_evt = 1'b0;
    d.key_sy = {q.key_sy[0], i_on_key_input_n};
    d.flt_m = i_fault;
    d.flt_s = q.flt_m;
    // Key must hold a new level for the whole window to count
    if (key_s != q.key_deb)
    begin
      d.deb_cnt = q.deb_cnt + opsq_pkg::CNT_W'(1);
      if (q.deb_cnt == opsq_pkg::CNT_W'(DEB_CYC - 1))
      begin
        d.key_deb = key_s;
        d.deb_cnt = '0;
        deb_evt = 1'b1;
      end
    end
    else
    begin
      d.deb_cnt = '0;
    end
    pb_fall = deb_evt && !key_s && (i_on_key_mode_select == opsq_pkg::MODE_PB);
    // Fault set wins over a clear in the same cycle
    d.cause = (q.cause & ~{3{i_cause_clr}}) | q.flt_s;

    case (q.st)
      opsq_pkg::ST_SHDN:
      begin
        if (q.wake || (i_on_key_mode_select == opsq_pkg::MODE_LOGIC && !key_s))
        begin
          d.st = opsq_pkg::ST_WAKE;
        end
      end
      opsq_pkg::ST_WAKE:
      begin
        // Consumed here, never in Shutdown, so a key set while leaving is not kept
        d.wake = 1'b0;
        if (q.cause == 3'h0 && !fault)
          d.st = opsq_pkg::ST_PUP;
        else
          d.st = opsq_pkg::ST_SHDN;
      end
      opsq_pkg::ST_PUP:
      begin
        if (fault)
          d.st = opsq_pkg::ST_IMSD;
        else if (tmr_done)
          d.st = opsq_pkg::ST_RON;
      end
      opsq_pkg::ST_RON:
      begin
        // Fault, then manual reset, then key, then software
        if (fault)
        begin
          d.st = opsq_pkg::ST_IMSD;
        end
        else if (i_manual_reset)
        begin
          d.st = opsq_pkg::ST_PDN;
          d.tgt_stby = 1'b0;
        end
        else if (i_on_key_mode_select == opsq_pkg::MODE_LOGIC && key_s)
        begin
          d.st = opsq_pkg::ST_PDN;
          d.tgt_stby = 1'b0;
        end
        else if (cmd_ok && (code == opsq_pkg::SC_COLD || code == opsq_pkg::SC_OFF))
        begin
          d.st = opsq_pkg::ST_PDN;
          d.tgt_stby = 1'b0;
        end
        else if (cmd_ok && code == opsq_pkg::SC_STBY)
        begin
          d.st = opsq_pkg::ST_PDN;
          d.tgt_stby = 1'b1;
        end
      end
      opsq_pkg::ST_PDN:
      begin
        if (fault)
          d.st = opsq_pkg::ST_IMSD;
        else if (tmr_done)
          d.st = q.tgt_stby ? opsq_pkg::ST_STBY : opsq_pkg::ST_BOFF;
      end
      opsq_pkg::ST_STBY:
      begin
        if (fault)
          d.st = opsq_pkg::ST_IMSD;
        else if (i_manual_reset || pb_fall || (cmd_ok && code == opsq_pkg::SC_EXIT))
          d.st = opsq_pkg::ST_WAKE;
      end
      // Immediate shutdown drops channels and serial at once; bias drops in the bias-off step
      opsq_pkg::ST_IMSD:
        d.st = opsq_pkg::ST_BOFF;
      opsq_pkg::ST_BOFF:
        d.st = opsq_pkg::ST_SHDN;
      default:
        d.st = opsq_pkg::ST_SHDN;
    endcase

    // Key wake only counts from Shutdown; presses while up are not kept
    if (q.st == opsq_pkg::ST_SHDN)
    begin
      // Button wakes on a press only; slide on any change; mode 3 never
      if (pb_fall || (deb_evt && i_on_key_mode_select == opsq_pkg::MODE_SLIDE))
        d.wake = 1'b1;
      if (i_on_key_mode_select == opsq_pkg::MODE_LOGIC && !key_s)
        d.wake = 1'b1;
    end
    if (cmd_ok && code == opsq_pkg::SC_COLD && !fault && !i_manual_reset)
      d.wake = 1'b1;

    for (int i = 0; i < opsq_pkg::NCH; i++)
    begin
      if (is_dead(d.st))
        d.on[i] = 1'b0;
      else if (d.st == opsq_pkg::ST_STBY)
        d.on[i] = forced[i];
      else if (forced[i])
        d.on[i] = 1'b1;
      else if (q.st == opsq_pkg::ST_PUP && tmr_evt && i_up_slot[i] == tmr_slot)
        d.on[i] = 1'b1;
      else if (q.st == opsq_pkg::ST_PDN && tmr_evt && i_dn_slot[i] == tmr_slot)
        d.on[i] = 1'b0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      q <= '0;
      q.st <= opsq_pkg::ST_SHDN;
      q.key_sy <= {2{opsq_pkg::KEY_RST}};
      q.key_deb <= opsq_pkg::KEY_RST;
    end
    else if (i_ce)
    begin
      q <= d;
    end
  end

  // ****************************************************************
  // Master timer
  // ****************************************************************
  assign tmr_up = (d.st == opsq_pkg::ST_PUP) && (q.st != opsq_pkg::ST_PUP);
  assign tmr_dn = (d.st == opsq_pkg::ST_PDN) && (q.st != opsq_pkg::ST_PDN);
  assign tmr_abort = (d.st == opsq_pkg::ST_IMSD);

  opsq_seq_timer #(
    .SLOT_CYC(SLOT_CYC),
    .DISCH_CYC(DISCH_CYC)
  ) u_timer (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_start_up(tmr_up),
    .i_start_dn(tmr_dn),
    .i_abort(tmr_abort),
    .o_evt(tmr_evt),
    .o_slot(tmr_slot),
    .o_done(tmr_done),
    .o_busy()
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_state = q.st;
  assign o_channel_on = q.on;
  assign o_bias_on = (q.st != opsq_pkg::ST_SHDN) && (q.st != opsq_pkg::ST_BOFF);
  assign o_serial_on = serial_live(q.st);
  // Sampled bias trades output ripple for quiescent current
  assign o_bias_lp = (q.st == opsq_pkg::ST_STBY) && i_bias_low_power_select;
  assign o_ctrl_lp = (q.st == opsq_pkg::ST_STBY) && i_bias_low_power_select;
  assign o_reset_cause_flags = opsq_pkg::opsq_cause_s'(q.cause);
  assign o_wake_flag = q.wake;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst || !i_ce);

  sequence imsd_path_sq;
    (q.st == opsq_pkg::ST_IMSD) ##1 (q.st == opsq_pkg::ST_BOFF) ##1
      (q.st == opsq_pkg::ST_SHDN);
  endsequence

  sequence ron_quiet_sq;
    (q.st == opsq_pkg::ST_RON) && !fault && !i_manual_reset;
  endsequence

  ron_entry_a: assert property ($rose(q.st == opsq_pkg::ST_RON) |->
      $past(q.st) == opsq_pkg::ST_PUP && $past(tmr_done) && o_serial_on)
    else $error("Resource On entered without power-up done");

  soft_off_a: assert property (ron_quiet_sq and cmd_ok && code == opsq_pkg::SC_OFF &&
      !(i_on_key_mode_select == opsq_pkg::MODE_LOGIC && key_s)
      |=> q.st == opsq_pkg::ST_PDN && !q.tgt_stby)
    else $error("Power-off command did not start power-down");

  stby_cmd_a: assert property (ron_quiet_sq and cmd_ok && code == opsq_pkg::SC_STBY &&
      !(i_on_key_mode_select == opsq_pkg::MODE_LOGIC && key_s)
      |=> q.st == opsq_pkg::ST_PDN && q.tgt_stby)
    else $error("Standby command did not start power-down to Standby");

  stby_chan_a: assert property ($rose(q.st == opsq_pkg::ST_STBY) |->
      q.on == $past(forced))
    else $error("Standby channel state differs from forced set");

  stby_bias_a: assert property (q.st == opsq_pkg::ST_STBY |-> o_bias_on && o_serial_on &&
      o_bias_lp == i_bias_low_power_select && o_ctrl_lp == o_bias_lp)
    else $error("Standby bias or serial state wrong");

  pdn_done_a: assert property (q.st == opsq_pkg::ST_PDN && tmr_done && !fault |=>
      q.st == ($past(q.tgt_stby) ? opsq_pkg::ST_STBY : opsq_pkg::ST_BOFF))
    else $error("Power-down end went to wrong state");

  stby_exit_a: assert property (q.st == opsq_pkg::ST_STBY && !fault && cmd_ok &&
      code == opsq_pkg::SC_EXIT |=> q.st == opsq_pkg::ST_WAKE)
    else $error("Exit-standby command ignored");

  fault_sd_a: assert property (fault && !is_dead(q.st) |=> imsd_path_sq)
    else $error("Fault did not shut down immediately");

  prio_a: assert property (fault && i_manual_reset && q.st == opsq_pkg::ST_RON |=>
      q.st == opsq_pkg::ST_IMSD && q.on == 4'h0)
    else $error("Manual reset took priority over fault");

  cold_wake_a: assert property (ron_quiet_sq and cmd_ok && code == opsq_pkg::SC_COLD |=>
      q.wake)
    else $error("Cold reset did not set wake flag");

  wake_fault_a: assert property (q.st == opsq_pkg::ST_WAKE && q.cause != 3'h0 |=>
      q.st == opsq_pkg::ST_SHDN)
    else $error("Wake proceeded with latched faults");

  pup_time_a: assert property ($rose(q.st == opsq_pkg::ST_PUP) |->
      q.st == opsq_pkg::ST_PUP throughout (##[1:1] 1'b1))
    else $error("Power-up left in its first cycle");
endmodule : opsq_on_off_ctrl
`default_nettype wire

// File: opsq_host_model.sv
// Host processor and on-key model driving the sequencer's far-side inputs
// ****************************************************************
// Host model
// ****************************************************************
`default_nettype none
module opsq_host_model #(
  parameter int COLD_WAIT_CYC = 40
) (
  input wire logic i_clk,
  output var logic o_on_key_input_n,
  output var opsq_pkg::opsq_cmd_s o_soft_control_field,
  output var logic o_manual_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  int cyc = 0;
  int cold_at = -100000;
  // Pull-up keeps the key released while nobody presses it
  initial
  begin
    o_on_key_input_n = 1'h1;
    o_soft_control_field = '{wr: 1'h0, code: 3'h0};
    o_manual_reset = 1'h0;
  end
  always @(posedge i_clk)
    cyc <= cyc + 1;
  task automatic set_key(input logic lvl);
    @(posedge i_clk);
    o_on_key_input_n <= lvl;
  endtask : set_key
  task automatic send_cmd(input logic [2:0] code);
    // Quiet time after a cold reset, scaled like the sequencer counts
    while (cyc - cold_at < COLD_WAIT_CYC)
      @(posedge i_clk);
    @(posedge i_clk);
    o_soft_control_field <= '{wr: 1'h1, code: code};
    if (code === opsq_pkg::SC_COLD)
      cold_at = cyc;
    @(posedge i_clk);
    // Stale code is inverted so nothing can lean on it
    o_soft_control_field <= '{wr: 1'h0, code: ~code};
  endtask : send_cmd
  task automatic pulse_reset();
    @(posedge i_clk);
    o_manual_reset <= 1'h1;
    @(posedge i_clk);
    o_manual_reset <= 1'h0;
  endtask : pulse_reset
endmodule : opsq_host_model
`default_nettype wire

// File: tb.sv
// Self-checking bench for the on/off controller and sequencer
// ****************************************************************
// Bench
// ****************************************************************
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SLOT = 4;
  localparam int DISCH = 8;
  localparam opsq_pkg::opsq_state_e SD = opsq_pkg::ST_SHDN;
  localparam opsq_pkg::opsq_state_e WK = opsq_pkg::ST_WAKE;
  localparam opsq_pkg::opsq_state_e PU = opsq_pkg::ST_PUP;
  localparam opsq_pkg::opsq_state_e RO = opsq_pkg::ST_RON;
  localparam opsq_pkg::opsq_state_e PD = opsq_pkg::ST_PDN;
  localparam opsq_pkg::opsq_state_e SB = opsq_pkg::ST_STBY;
  localparam opsq_pkg::opsq_state_e IM = opsq_pkg::ST_IMSD;
  localparam opsq_pkg::opsq_state_e BO = opsq_pkg::ST_BOFF;
  logic clk;
  logic rst;
  logic ce;
  logic [1:0] mode;
  opsq_pkg::opsq_cause_s fault;
  logic clr;
  logic lp;
  logic [3:0][2:0] en;
  logic [3:0][1:0] up;
  logic [3:0][1:0] dn;
  logic key_n;
  opsq_pkg::opsq_cmd_s scmd;
  logic mrst;
  opsq_pkg::opsq_state_e st;
  logic [3:0] ch;
  logic bias;
  logic ser;
  logic blp;
  logic clp;
  opsq_pkg::opsq_cause_s flags;
  logic wake;
  int errors;
  int comparisons;
  opsq_on_off_ctrl #(
    .SLOT_CYC(SLOT),
    .DISCH_CYC(DISCH),
    .DEB_CYC(3)
  ) i_dut (
    .i_clk(clk),
    .i_rst(rst),
    .i_ce(ce),
    .i_on_key_input_n(key_n),
    .i_on_key_mode_select(mode),
    .i_soft_control_field(scmd),
    .i_manual_reset(mrst),
    .i_fault(fault),
    .i_cause_clr(clr),
    .i_bias_low_power_select(lp),
    .i_channel_enable_field(en),
    .i_up_slot(up),
    .i_dn_slot(dn),
    .o_state(st),
    .o_channel_on(ch),
    .o_bias_on(bias),
    .o_bias_lp(blp),
    .o_ctrl_lp(clp),
    .o_serial_on(ser),
    .o_reset_cause_flags(flags),
    .o_wake_flag(wake)
  );
  opsq_host_model #(
    .COLD_WAIT_CYC(40)
  ) i_host (
    .i_clk(clk),
    .o_on_key_input_n(key_n),
    .o_soft_control_field(scmd),
    .o_manual_reset(mrst)
  );
  initial
  begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize
  task automatic mismatch(input string msg);
    errors++;
    $display("mismatch at %0t: %s", $time, msg);
  endtask : mismatch
  task automatic cmp_state(input opsq_pkg::opsq_state_e got, input opsq_pkg::opsq_state_e exp);
    comparisons++;
    if (got !== exp)
      mismatch($sformatf("state %h expected %h", got, exp));
  endtask : cmp_state
  task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp)
      mismatch($sformatf("%s %h expected %h", what, got, exp));
  endtask : cmp_val
  function automatic logic [3:0] fmask();
    for (int i = 0; i < 4; i++)
      fmask[i] = en[i] === opsq_pkg::EN_FORCE_A || en[i] === opsq_pkg::EN_FORCE_B;
  endfunction : fmask
  task automatic randomize_cfg();
    for (int i = 0; i < 4; i++)
    begin
      en[i] <= (i == 0) ? 3'h6 + 3'($urandom_range(1)) : 3'($urandom_range(5));
      up[i] <= 2'($urandom_range(3));
      dn[i] <= 2'($urandom_range(3));
    end
  endtask : randomize_cfg
  task automatic chk_out();
    logic s;
    logic r;
    s = st === SB;
    r = st === RO;
    cmp_val({4'h0, ch}, {4'h0, r ? 4'hf : (s ? fmask() : 4'h0)}, "channels");
    cmp_val({4'h0, bias, ser, blp, clp}, {4'h0, s | r, s | r, s & lp, s & lp}, "bias");
  endtask : chk_out
  // A channel not yet switched when the state moves on counts as last
  task automatic seq_order(input int t[4], input logic [3:0][1:0] s);
    int a;
    int b;
    logic [3:0] f;
    f = fmask();
    for (int i = 0; i < 4; i++)
      for (int j = 0; j < 4; j++)
        if (!f[i] && !f[j])
        begin
          a = (t[i] == 0) ? 1000 : t[i];
          b = (t[j] == 0) ? 1000 : t[j];
          cmp_val(8'(a < b), 8'(s[i] < s[j]), "slot order");
        end
  endtask : seq_order
  task automatic follow(input opsq_pkg::opsq_state_e path[$]);
    opsq_pkg::opsq_state_e prev;
    logic [3:0] last;
    int n;
    int t[4];
    foreach (path[k])
    begin
      #1;
      prev = st;
      last = ch;
      n = 0;
      t = '{default: 0};
      while (st === prev && n < 300)
      begin
        @(posedge clk);
        #1;
        n++;
        for (int i = 0; i < 4; i++)
          if (ch[i] !== last[i])
            t[i] = n;
        last = ch;
      end
      if (n >= 300)
      begin
        mismatch("state wait timed out");
        summarize();
      end
      if (prev === PU)
        seq_order(t, up);
      if (prev === PD)
      begin
        seq_order(t, dn);
        cmp_val(8'(n <= 4 * (SLOT + 1) + DISCH + 4), 8'h1, "power-down length");
      end
      cmp_state(st, path[k]);
    end
  endtask : follow
  task automatic cmd(input logic [2:0] c, input opsq_pkg::opsq_state_e e);
    i_host.send_cmd(c);
    #1;
    cmp_state(st, e);
  endtask : cmd
  initial
  begin
    rst = 1'h1;
    ce = 1'h1;
    mode = opsq_pkg::MODE_LOGIC;
    fault = '{undervoltage_lockout_flag: 1'h0, overvoltage_lockout_flag: 1'h0, thermal_overload_flag: 1'h0};
    clr = 1'h0;
    lp = 1'h1;
    en = '0;
    up = '0;
    dn = '0;
    errors = 0;
    comparisons = 0;
    void'($urandom(48));
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    randomize_cfg();
    @(posedge clk);
    #1;
    cmp_state(st, SD);
    chk_out();
    cmp_val({4'h0, flags, wake}, 8'h0, "reset flags");
    i_host.set_key(1'h0);
    follow('{WK, PU, RO});
    chk_out();
    cmd(opsq_pkg::SC_STBY, PD);
    follow('{SB});
    for (int v = 0; v < 2; v++)
    begin
      @(posedge clk);
      lp <= v[0];
      @(posedge clk);
      #1;
      chk_out();
    end
    cmd(opsq_pkg::SC_EXIT, WK);
    follow('{PU, RO});
    i_host.pulse_reset();
    #1;
    cmp_state(st, PD);
    follow('{BO, SD, WK, PU, RO});
    i_host.set_key(1'h1);
    follow('{PD, BO, SD});
    chk_out();
    i_host.set_key(1'h0);
    follow('{WK, PU, RO});
    @(posedge clk);
    mode <= 2'h3;
    cmd(opsq_pkg::SC_COLD, PD);
    cmp_val({7'h0, wake}, 8'h1, "wake flag");
    follow('{BO, SD, WK, PU, RO});
    cmd(opsq_pkg::SC_OFF, PD);
    follow('{BO, SD});
    cmd(opsq_pkg::SC_EXIT, SD);
    i_host.set_key(1'h1);
    repeat (12) @(posedge clk);
    mode <= opsq_pkg::MODE_PB;
    i_host.set_key(1'h0);
    follow('{WK, PU, RO});
    i_host.set_key(1'h1);
    repeat (12) @(posedge clk);
    cmd(opsq_pkg::SC_STBY, PD);
    follow('{SB});
    i_host.set_key(1'h0);
    follow('{WK, PU, RO});
    i_host.set_key(1'h1);
    repeat (12) @(posedge clk);
    cmd(opsq_pkg::SC_STBY, PD);
    follow('{SB});
    // Frozen clock enable must drop a manual reset pulse
    @(posedge clk);
    ce <= 1'h0;
    i_host.pulse_reset();
    repeat (2) @(posedge clk);
    ce <= 1'h1;
    #1;
    cmp_state(st, SB);
    i_host.pulse_reset();
    #1;
    cmp_state(st, WK);
    follow('{PU, RO});
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clk);
      fault <= opsq_pkg::opsq_cause_s'(3'h4 >> k);
      mode <= k[0] ? opsq_pkg::MODE_SLIDE : opsq_pkg::MODE_PB;
      // Manual reset lands on the edge where the synced fault is first seen
      @(posedge clk);
      i_host.pulse_reset();
      #1;
      cmp_state(st, IM);
      cmp_val({5'h0, flags}, {5'h0, 3'h4 >> k}, "cause flags");
      follow('{BO, SD});
      chk_out();
      @(posedge clk);
      fault <= '{undervoltage_lockout_flag: 1'h0, overvoltage_lockout_flag: 1'h0, thermal_overload_flag: 1'h0};
      i_host.set_key(1'h0);
      follow('{WK, SD});
      i_host.set_key(1'h1);
      if (k[0])
        follow('{WK, SD});
      repeat (12) @(posedge clk);
      cmp_state(st, SD);
      clr <= 1'h1;
      @(posedge clk);
      clr <= 1'h0;
      randomize_cfg();
      i_host.set_key(1'h0);
      follow('{WK, PU, RO});
      i_host.set_key(1'h1);
      repeat (12) @(posedge clk);
    end
    summarize();
  end
endmodule : tb
`default_nettype wire
